// ---- core/smg_regs.svh ----
// register layout, reset values and bit count for the serial mode and gain receiver
`ifndef SMG_REGS_SVH
`define SMG_REGS_SVH
`define SMG_WORD_BITS      8
`define SMG_MODE_LSB       0
`define SMG_MODE_MSB       2
`define SMG_GAIN_LSB       3
`define SMG_GAIN_MSB       7
`define SMG_MODE_RST       3'h0
`define SMG_GAIN_RST       5'h00
`define SMG_MODE_STANDBY   3'h0
`define SMG_CNT_FULL       4'h8
`endif

// ---- core/smg_pkg.sv ----
// types shared by the serial mode and gain receiver
package smg_pkg;
	typedef logic [2:0] smg_mode_t;
	typedef logic [4:0] smg_gain_t;
	typedef logic [7:0] smg_word_t;
endpackage

// ---- core/smg_sync.sv ----
// two flip-flop synchroniser for one pin, with edge flags taken after the second stage
module smg_sync
(
	input  wire logic i_clk_sys,
	input  wire logic i_resetn,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
	} smg_sync_s;
	smg_sync_s st_r;
	smg_sync_s st_nxt;
	// shift the pin through the stages
	always_comb
	begin
		st_nxt    = st_r;
		st_nxt.s1 = i_pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	// edges are seen only between stages two and three
	assign o_level = st_r.s2;
	assign o_rise  = st_r.s2 & ~st_r.s3;
	assign o_fall  = ~st_r.s2 & st_r.s3;
endmodule

// ---- core/smg_receiver.sv ----
// serial mode and gain control receiver: shift register, bit counter, latch on strobe fall
`include "smg_regs.svh"
module smg_receiver
(
	input  wire logic             i_clk_sys,
	input  wire logic             i_resetn,
	input  wire logic             i_serial_clk,
	input  wire logic             i_serial_data,
	input  wire logic             i_load_strobe_n,
	output smg_pkg::smg_mode_t    o_mode,
	output smg_pkg::smg_gain_t    o_gain,
	output logic                  o_standby,
	output logic                  o_wake_start
);
	// all receiver state, registered as one word
	typedef struct packed
	{
		smg_pkg::smg_word_t shift;
		logic [3:0]         cnt;
		smg_pkg::smg_mode_t mode;
		smg_pkg::smg_gain_t gain;
		logic               standby;
		logic               wake;
	} smg_state_s;
	smg_state_s st_r;
	smg_state_s st_nxt;
	// synchronised levels and edges of the three pins
	logic       sclk_rise;
	logic       data_lvl;
	logic       strobe_lvl;
	logic       strobe_fall;
	// pins cross into the system clock through two flops each
	smg_sync u_sclk
	(
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_pin     (i_serial_clk),
		.o_level   (),
		.o_rise    (sclk_rise),
		.o_fall    ()
	);
	smg_sync u_data
	(
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_pin     (i_serial_data),
		.o_level   (data_lvl),
		.o_rise    (),
		.o_fall    ()
	);
	smg_sync u_strb
	(
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_pin     (i_load_strobe_n),
		.o_level   (strobe_lvl),
		.o_rise    (),
		.o_fall    (strobe_fall)
	);
	// next-state: shift on clock rise, latch on strobe fall
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.wake   = 1'h0;
		if (strobe_fall)
		begin
			if (st_r.cnt == `SMG_CNT_FULL)
			begin
				// both fields change in one step
				st_nxt.mode    = st_r.shift[`SMG_MODE_MSB:`SMG_MODE_LSB];
				st_nxt.gain    = st_r.shift[`SMG_GAIN_MSB:`SMG_GAIN_LSB];
				st_nxt.standby = (st_r.shift[`SMG_MODE_MSB:`SMG_MODE_LSB]
					== `SMG_MODE_STANDBY);
				st_nxt.wake    = st_r.standby & (st_r.shift[`SMG_MODE_MSB:`SMG_MODE_LSB]
					!= `SMG_MODE_STANDBY);
			end
			st_nxt.cnt = 4'h0;
		end
		else if (strobe_lvl)
		begin
			// a fresh sequence counts from zero while strobe is high
			if (sclk_rise && st_r.cnt < `SMG_CNT_FULL)
			begin
				// lsb arrives first, so new bits enter at the top
				st_nxt.shift = {data_lvl, st_r.shift[7:1]};
				st_nxt.cnt   = st_r.cnt + 4'h1;
			end
		end
		else
			st_nxt.cnt = 4'h0;
	end
	// asynchronous reset stands in for power-on reset
	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st_r         <= '0;
			st_r.mode    <= `SMG_MODE_RST;
			st_r.gain    <= `SMG_GAIN_RST;
			st_r.standby <= 1'h1;
		end
		else
			st_r <= st_nxt;
	end
	assign o_mode       = st_r.mode;
	assign o_gain       = st_r.gain;
	assign o_standby    = st_r.standby;
	assign o_wake_start = st_r.wake;
	// a full word on strobe fall reaches the outputs on the next edge
	property p_latch;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(strobe_fall && st_r.cnt == `SMG_CNT_FULL) |=>
			({o_gain, o_mode} == $past(st_r.shift));
	endproperty
	a_latch: assert property (p_latch) else $error("word not latched");
	property p_short_hold;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(strobe_fall && st_r.cnt != `SMG_CNT_FULL) |=> $stable(o_mode) && $stable(o_gain);
	endproperty
	a_short_hold: assert property (p_short_hold) else $error("short word latched");
	property p_cnt_cap;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		st_r.cnt <= `SMG_CNT_FULL;
	endproperty
	a_cnt_cap: assert property (p_cnt_cap) else $error("bit count overran");
	property p_ignore;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(st_r.cnt == `SMG_CNT_FULL && !strobe_fall) |=> $stable(st_r.shift);
	endproperty
	a_ignore: assert property (p_ignore) else $error("extra bit shifted");
	property p_shift;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(sclk_rise && strobe_lvl && !strobe_fall && st_r.cnt < `SMG_CNT_FULL) |=>
			(st_r.shift[7] == $past(data_lvl) && st_r.cnt == $past(st_r.cnt) + 4'h1);
	endproperty
	a_shift: assert property (p_shift) else $error("bit not captured");
	property p_clear;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(!strobe_lvl) |=> (st_r.cnt == 4'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared");
	property p_standby;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		o_standby == (o_mode == `SMG_MODE_STANDBY);
	endproperty
	a_standby: assert property (p_standby) else $error("standby mismatch");
	property p_wake;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		o_wake_start |-> ($past(o_standby) && !o_standby);
	endproperty
	a_wake: assert property (p_wake) else $error("wake without leaving standby");
	// a wake pulse lasts a single cycle
	property p_wake_pulse;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		o_wake_start |=> !o_wake_start;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
	// a full word that leaves standby must raise the wake pulse
	property p_wake_cause;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(strobe_fall && st_r.cnt == `SMG_CNT_FULL && o_standby &&
			st_r.shift[`SMG_MODE_MSB:`SMG_MODE_LSB] != `SMG_MODE_STANDBY) |=> o_wake_start;
	endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake pulse missing");
	// a wake pulse only ever follows a valid latch
	property p_wake_latch;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		!(strobe_fall && st_r.cnt == `SMG_CNT_FULL) |=> !o_wake_start;
	endproperty
	a_wake_latch: assert property (p_wake_latch) else $error("stray wake pulse");
	// a full word with mode zero puts the amplifier into standby
	property p_latch_standby;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(strobe_fall && st_r.cnt == `SMG_CNT_FULL &&
			st_r.shift[`SMG_MODE_MSB:`SMG_MODE_LSB] == `SMG_MODE_STANDBY) |=> o_standby;
	endproperty
	a_latch_standby: assert property (p_latch_standby) else $error("standby not entered");
	// no wake pulse while standby is held
	property p_standby_quiet;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		o_standby |-> !o_wake_start;
	endproperty
	a_standby_quiet: assert property (p_standby_quiet) else $error("wake in standby");
	// settings move only after a strobe fall
	property p_hold;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		!strobe_fall |=> $stable(o_mode) && $stable(o_gain) && $stable(o_standby);
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved without latch");
	// while the strobe is low nothing enters the shift register
	property p_low_quiet;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		!strobe_lvl |=> $stable(st_r.shift);
	endproperty
	a_low_quiet: assert property (p_low_quiet) else $error("shift with strobe low");
	// while the strobe is high, without a serial clock rise the register and the count stand still
	property p_no_rise;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(strobe_lvl && !sclk_rise) |=> $stable(st_r.shift) && $stable(st_r.cnt);
	endproperty
	a_no_rise: assert property (p_no_rise) else $error("shift without clock rise");
	// the count only steps up by one or returns to zero
	property p_cnt_step;
		@(posedge i_clk_sys) disable iff (!i_resetn)
		(st_r.cnt != $past(st_r.cnt)) |->
			(st_r.cnt == $past(st_r.cnt) + 4'h1 || st_r.cnt == 4'h0);
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("bit count jumped");
	// reset leaves the settings in standby with a cleared count
	property p_reset_state;
		@(posedge i_clk_sys)
		!i_resetn |=> (o_mode == `SMG_MODE_RST && o_gain == `SMG_GAIN_RST && o_standby &&
			!o_wake_start && st_r.cnt == 4'h0);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule

// ---- testbench/smg_host.sv ----
// host model that shifts mode and gain words into the receiver
module smg_host
(
	input  wire logic i_clk,
	output logic      o_sclk,
	output logic      o_sdata,
	output logic      o_strobe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle levels: clock still low, strobe high
	initial
	begin
		o_sclk = 1'h0;
		o_sdata = 1'h0;
		o_strobe_n = 1'h1;
	end
	// one frame of n bits, data set while the clock is low
	task automatic send(input logic [15:0] bits, input int n);
		@(posedge i_clk);
		#1 o_strobe_n = 1'h1;
		#16;
		for (int i = 0; i < n; i++)
		begin
			o_sdata = bits[i];
			#16 o_sclk = 1'h1;
			#16 o_sclk = 1'h0;
		end
		o_sdata = ~o_sdata; // stale data is not left on the line
		#16 o_strobe_n = 1'h0;
		#32;
	endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the serial mode and gain receiver
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic               i_clk_sys;
	logic               i_resetn;
	logic               sclk;
	logic               sdata;
	logic               strobe_n;
	smg_pkg::smg_mode_t o_mode;
	smg_pkg::smg_gain_t o_gain;
	logic               o_standby;
	logic               o_wake_start;
	int                 bad_count;
	int                 n_checks;
	int                 wakes;
	int                 exp_wakes;
	int                 n;
	logic [7:0]         exp_word;
	logic [15:0]        stim;
	logic [7:0]         new_word;
	int                 bit_q[$];
	int                 lens[6] = '{8, 5, 11, 8, 0, 8};
	smg_host smg_host_i(.i_clk(i_clk_sys), .o_sclk(sclk), .o_sdata(sdata),
		.o_strobe_n(strobe_n));
	smg_receiver smg_receiver_i(.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_serial_clk(sclk), .i_serial_data(sdata), .i_load_strobe_n(strobe_n),
		.o_mode(o_mode), .o_gain(o_gain), .o_standby(o_standby),
		.o_wake_start(o_wake_start));
	// 250 MHz system clock
	initial
	begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	// count wake pulses as they occur
	always @(posedge i_clk_sys)
		if (o_wake_start === 1'b1)
			wakes++;
	// prints counts and verdict, ends the run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog against a hung run
	initial
	begin
		#50000;
		bad_count++;
		report_and_stop();
	end
	// frames of random words, short and long, against the model
	initial
	begin
		i_resetn = 1'h0;
		bad_count = 0;
		n_checks = 0;
		wakes = 0;
		exp_wakes = 0;
		exp_word = 8'h00;
		void'($urandom(32'h951bdd55));
		repeat (5) @(posedge i_clk_sys);
		#1 i_resetn = 1'h1;
		`CHK(o_mode, 3'h0)
		`CHK(o_standby, 1'h1)
		for (int t = 0; t < 24; t++)
		begin
			stim = 16'($urandom());
			stim[2:0] = 3'(t);
			if (t == 2)
				stim[7:3] = 5'h1f;
			if (t == 9)
				stim[7:3] = 5'h00;
			n = lens[t % 6];
			// a reset in mid-run brings back the idle settings
			if (t == 12)
			begin
				@(posedge i_clk_sys);
				#1 i_resetn = 1'h0;
				repeat (5) @(posedge i_clk_sys);
				#1 i_resetn = 1'h1;
				exp_word = 8'h00;
				`CHK(o_gain, 5'h00)
				`CHK(o_standby, 1'h1)
			end
			smg_host_i.send(stim, n);
			// model: bits arrive lsb first, only the first eight of a frame count
			bit_q.delete();
			for (int b = 0; b < n; b++)
				bit_q.push_back(int'(stim[b]));
			if (bit_q.size() >= 8)
			begin
				new_word = 8'h00;
				for (int b = 0; b < 8; b++)
					new_word[b] = (bit_q[b] != 0);
				if (exp_word[2:0] == 3'h0 && new_word[2:0] != 3'h0)
					exp_wakes++;
				exp_word = new_word;
			end
			`CHK(o_mode, exp_word[2:0])
			`CHK(o_gain, exp_word[7:3])
			`CHK(o_standby, exp_word[2:0] == 3'h0)
			`CHK(wakes, exp_wakes)
			$display("test %0d done", t);
		end
		report_and_stop();
	end
endmodule
